/* design/prws_regs.vh */
// Purpose: constants for the peripheral register window select block
// Assumes: 24-bit cpu address, 8-bit data
// Notes:   own register addresses sit in the top page
`ifndef PRWS_REGS_VH
`define PRWS_REGS_VH

`define PRWS_AW              24
`define PRWS_DW              8

// own control registers
`define PRWS_ADDR_SYSCTL     24'hFFFE10
`define PRWS_ADDR_STCTL      24'hFFFE11
`define PRWS_ADDR_SYSCTL3    24'hFFFE12

// system_control fields
`define PRWS_SC_KEYWIN       1
`define PRWS_SC_RAMEN        0
`define PRWS_SC_KEYWIN_RST   1'h0
`define PRWS_SC_RAMEN_RST    1'h1

// serial_timer_control fields
`define PRWS_ST_RATE_HI      7
`define PRWS_ST_RATE_LO      5
`define PRWS_ST_SERWIN       4
`define PRWS_ST_RATE_RST     3'h0
`define PRWS_ST_SERWIN_RST   1'h0

// system_control_three fields
`define PRWS_S3_EXTMAP       5
`define PRWS_S3_EXTMAP_RST   1'h0

// shared windows
`define PRWS_KT_A_LO         24'hFFFFF0
`define PRWS_KT_A_HI         24'hFFFFF7
`define PRWS_KT_B_LO         24'hFFFFFC
`define PRWS_KT_B_HI         24'hFFFFFF
`define PRWS_S1_A_LO         24'hFFFF88
`define PRWS_S1_A_HI         24'hFFFF89
`define PRWS_S1_B_LO         24'hFFFF8E
`define PRWS_S1_B_HI         24'hFFFF8F
`define PRWS_S2_A_LO         24'hFFFFA0
`define PRWS_S2_A_HI         24'hFFFFA1
`define PRWS_S2_B_LO         24'hFFFFA6
`define PRWS_S2_B_HI         24'hFFFFA7
`define PRWS_W0_A_LO         24'hFFFFD8
`define PRWS_W0_A_HI         24'hFFFFD9
`define PRWS_W0_B_LO         24'hFFFFDE
`define PRWS_W0_B_HI         24'hFFFFDF
`define PRWS_TWRST_ADDR      24'hFFFEE6

`define PRWS_ZERO8           8'h00
`define PRWS_RDVALID_RST     1'h0

`endif

/* design/prws_window_select.v */
// Purpose: control bits steering shared peripheral windows, plus ram enable
// Assumes: cpu bus logic on core_clk, single-cycle rd/wr strobes
// Notes:   peripheral selects are combinational, read data is registered
`timescale 1ns/1ps
`default_nettype none
`include "prws_regs.vh"

module prws_window_select (
   input  wire                    core_clk,          // cpu clock
   input  wire                    rst_n,             // async reset, active low
   input  wire [`PRWS_AW-1:0]     busAddr,           // cpu address
   input  wire                    busRd,             // read strobe
   input  wire                    busWr,             // write strobe
   input  wire [`PRWS_DW-1:0]     busWrData,         // write data
   output reg  [`PRWS_DW-1:0]     busRdData_r,       // read data, own registers
   output reg                     busRdValid_r,      // read data valid pulse
   output wire                    timerSel,          // 8-bit timer set selected
   output wire                    keypadSel,         // keypad masks / pull-up selected
   output wire                    asyncSerialCh1Sel, // async serial ch1 selected
   output wire                    asyncSerialCh2Sel, // async serial ch2 selected
   output wire                    twowireCh1Sel,     // two-wire ch1 selected
   output wire                    pwmConverterSel,   // pwm converter selected
   output wire                    twowireCh0Sel,     // two-wire ch0 selected
   output wire                    twowireResetSel,   // two-wire reset control selected
   output wire                    prohibitedAccess,  // strobe into a forbidden window
   output wire                    onchipRamEnable,   // internal ram enable level
   output wire [2:0]              twowireRateSel,    // two-wire master rate select
   output wire                    extendedMapSelect  // extended register map level
);

   localparam integer NRANGE = 8;                   // four windows, two ranges each
   localparam integer KT_IDX = 0;                   // keypad / timer entries
   localparam integer S1_IDX = 2;                   // channel 1 entries
   localparam integer S2_IDX = 4;                   // channel 2 / pwm entries
   localparam integer W0_IDX = 6;                   // two-wire channel 0 entries

   // range table, entry 0 in the low bits; both ends inclusive
   localparam [NRANGE*`PRWS_AW-1:0] RANGE_LO = {
      `PRWS_W0_B_LO,
      `PRWS_W0_A_LO,
      `PRWS_S2_B_LO,
      `PRWS_S2_A_LO,
      `PRWS_S1_B_LO,
      `PRWS_S1_A_LO,
      `PRWS_KT_B_LO,
      `PRWS_KT_A_LO
   };

   localparam [NRANGE*`PRWS_AW-1:0] RANGE_HI = {
      `PRWS_W0_B_HI,
      `PRWS_W0_A_HI,
      `PRWS_S2_B_HI,
      `PRWS_S2_A_HI,
      `PRWS_S1_B_HI,
      `PRWS_S1_A_HI,
      `PRWS_KT_B_HI,
      `PRWS_KT_A_HI
   };

   // control state, one flop per stored bit
   reg                            keypadWindowSelect_r;
   reg                            onchipRamEnable_r;
   reg  [2:0]                     twowireRateSel_r;
   reg                            serialWindowSelect_r;
   reg                            extendedMapSelect_r;

   // next values, kept apart so each flop has one plain load
   reg                            keypadWindowSelect_nxt;
   reg                            onchipRamEnable_nxt;
   reg  [2:0]                     twowireRateSel_nxt;
   reg                            serialWindowSelect_nxt;
   reg                            extendedMapSelect_nxt;
   reg  [`PRWS_DW-1:0]            busRdData_nxt;
   reg                            busRdValid_nxt;

   reg  [`PRWS_DW-1:0]            sysCtlView;
   reg  [`PRWS_DW-1:0]            stCtlView;
   reg  [`PRWS_DW-1:0]            sysCtl3View;
   reg  [`PRWS_DW-1:0]            rdMux;
   reg                            keyWinEff;
   reg                            serWinEff;

   wire                           access;
   wire                           hitSysCtl;
   wire                           hitStCtl;
   wire                           hitSysCtl3;
   wire                           ownHit;
   wire                           wrSysCtl;
   wire                           wrStCtl;
   wire                           wrSysCtl3;
   wire                           rdOwn;
   wire [NRANGE-1:0]              rangeHit;
   wire                           inKeyTimer;
   wire                           inSer1;
   wire                           inSer2;
   wire                           inWire0;
   wire                           inWireRst;

   // address and window-bit decode of each set, before the strobe gates it
   wire                           timerView;
   wire                           keypadView;
   wire                           asyncSerialCh1View;
   wire                           asyncSerialCh2View;
   wire                           twowireCh1View;
   wire                           pwmConverterView;
   wire                           twowireCh0View;
   wire                           twowireResetView;
   wire                           prohibitedView;

   genvar                         g;

   // own register strobes; a read and a write together are not expected
   assign access     = busRd | busWr;
   assign hitSysCtl  = (busAddr == `PRWS_ADDR_SYSCTL);
   assign hitStCtl   = (busAddr == `PRWS_ADDR_STCTL);
   assign hitSysCtl3 = (busAddr == `PRWS_ADDR_SYSCTL3);
   assign ownHit     = hitSysCtl | hitStCtl | hitSysCtl3;
   assign wrSysCtl   = busWr & hitSysCtl;
   assign wrStCtl    = busWr & hitStCtl;
   assign wrSysCtl3  = busWr & hitSysCtl3;
   assign rdOwn      = busRd & ownHit;

   // one comparator pair per range entry; full compares keep every bound visible
   generate
      for (g = 0; g < NRANGE; g = g + 1) begin : g_range
         assign rangeHit[g] = (busAddr >= RANGE_LO[g*`PRWS_AW +: `PRWS_AW]) &&
                              (busAddr <= RANGE_HI[g*`PRWS_AW +: `PRWS_AW]);
      end
   endgenerate

   assign inKeyTimer = rangeHit[KT_IDX] | rangeHit[KT_IDX + 1];
   assign inSer1     = rangeHit[S1_IDX] | rangeHit[S1_IDX + 1];
   assign inSer2     = rangeHit[S2_IDX] | rangeHit[S2_IDX + 1];
   assign inWire0    = rangeHit[W0_IDX] | rangeHit[W0_IDX + 1];
   assign inWireRst  = (busAddr == `PRWS_TWRST_ADDR);

   // extended map: bits keep their value but decode falls back to reset views
   always @* begin
      keyWinEff = keypadWindowSelect_r;
      serWinEff = serialWindowSelect_r;
      if (extendedMapSelect_r) begin
         keyWinEff = `PRWS_SC_KEYWIN_RST;
         serWinEff = `PRWS_ST_SERWIN_RST;
      end
   end

   // one set per shared range, never both; the two-wire ch0 range has none while serWinEff is 0
   assign timerView          = inKeyTimer & ~keyWinEff;
   assign keypadView         = inKeyTimer &  keyWinEff;
   assign asyncSerialCh1View = inSer1 & ~serWinEff;
   assign asyncSerialCh2View = inSer2 & ~serWinEff;
   assign twowireCh1View     = inSer1 &  serWinEff;
   assign pwmConverterView   = inSer2 &  serWinEff;
   assign twowireCh0View     = inWire0 & serWinEff;
   assign twowireResetView   = inWireRst & serWinEff;
   assign prohibitedView     = inWire0 & ~serWinEff;

   // only the selected set sees the strobe, so the hidden set is untouched
   assign timerSel          = access & timerView;
   assign keypadSel         = access & keypadView;
   assign asyncSerialCh1Sel = access & asyncSerialCh1View;
   assign asyncSerialCh2Sel = access & asyncSerialCh2View;
   assign twowireCh1Sel     = access & twowireCh1View;
   assign pwmConverterSel   = access & pwmConverterView;
   assign twowireCh0Sel     = access & twowireCh0View;
   assign twowireResetSel   = access & twowireResetView;
   // no set answers here; flagged so a bus monitor can trap it
   // nothing else guards this window, software must keep out
   assign prohibitedAccess  = access & prohibitedView;

   // levels come straight from the flops
   assign onchipRamEnable   = onchipRamEnable_r;
   assign twowireRateSel    = twowireRateSel_r;
   assign extendedMapSelect = extendedMapSelect_r;

   // system_control next value; window bits act from the cycle after the write
   always @* begin
      keypadWindowSelect_nxt = keypadWindowSelect_r;
      onchipRamEnable_nxt    = onchipRamEnable_r;
      if (wrSysCtl) begin
         keypadWindowSelect_nxt = busWrData[`PRWS_SC_KEYWIN];
         onchipRamEnable_nxt    = busWrData[`PRWS_SC_RAMEN];
      end
   end

   // serial_timer_control next value; rate bits only feed the two-wire divider
   always @* begin
      twowireRateSel_nxt     = twowireRateSel_r;
      serialWindowSelect_nxt = serialWindowSelect_r;
      if (wrStCtl) begin
         twowireRateSel_nxt     = busWrData[`PRWS_ST_RATE_HI:`PRWS_ST_RATE_LO];
         serialWindowSelect_nxt = busWrData[`PRWS_ST_SERWIN];
      end
   end

   // system_control_three next value
   always @* begin
      extendedMapSelect_nxt = extendedMapSelect_r;
      if (wrSysCtl3) begin
         extendedMapSelect_nxt = busWrData[`PRWS_S3_EXTMAP];
      end
   end

   // ram enable resets to 1 so the internal ram is usable straight away
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         keypadWindowSelect_r <= `PRWS_SC_KEYWIN_RST;
         onchipRamEnable_r    <= `PRWS_SC_RAMEN_RST;
      end else begin
         keypadWindowSelect_r <= keypadWindowSelect_nxt;
         onchipRamEnable_r    <= onchipRamEnable_nxt;
      end
   end

   // rate and serial window share one write strobe
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         twowireRateSel_r     <= `PRWS_ST_RATE_RST;
         serialWindowSelect_r <= `PRWS_ST_SERWIN_RST;
      end else begin
         twowireRateSel_r     <= twowireRateSel_nxt;
         serialWindowSelect_r <= serialWindowSelect_nxt;
      end
   end

   // extended map select starts in the compatible map
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         extendedMapSelect_r <= `PRWS_S3_EXTMAP_RST;
      end else begin
         extendedMapSelect_r <= extendedMapSelect_nxt;
      end
   end

   // register images; unimplemented bits read as zero, writes to them are lost
   always @* begin
      sysCtlView                  = `PRWS_ZERO8;
      sysCtlView[`PRWS_SC_KEYWIN] = keypadWindowSelect_r;
      sysCtlView[`PRWS_SC_RAMEN]  = onchipRamEnable_r;
   end

   always @* begin
      stCtlView                                    = `PRWS_ZERO8;
      stCtlView[`PRWS_ST_RATE_HI:`PRWS_ST_RATE_LO] = twowireRateSel_r;
      stCtlView[`PRWS_ST_SERWIN]                   = serialWindowSelect_r;
   end

   always @* begin
      sysCtl3View                  = `PRWS_ZERO8;
      sysCtl3View[`PRWS_S3_EXTMAP] = extendedMapSelect_r;
   end

   // answer only for own registers; peripheral sets answer for themselves
   always @* begin
      rdMux = `PRWS_ZERO8;
      if (hitSysCtl) begin
         rdMux = sysCtlView;
      end else if (hitStCtl) begin
         rdMux = stCtlView;
      end else if (hitSysCtl3) begin
         rdMux = sysCtl3View;
      end
   end

   // read data holds until the next own read
   // a read of a shared range gets no answer from this block
   always @* begin
      busRdValid_nxt = rdOwn;
      busRdData_nxt  = busRdData_r;
      if (rdOwn) begin
         busRdData_nxt = rdMux;
      end
   end

   // valid is a one-cycle pulse after each own read
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         busRdData_r  <= `PRWS_ZERO8;
         busRdValid_r <= `PRWS_RDVALID_RST;
      end else begin
         busRdData_r  <= busRdData_nxt;
         busRdValid_r <= busRdValid_nxt;
      end
   end

endmodule // prws_window_select
`default_nettype wire

/* sim/prws_cpu_model.sv */
// Purpose: cpu bus master driving single-cycle accesses
// Assumes: strobes launched at the falling edge
// Notes:   released bus shows the inverse, never stale values
`timescale 1ns/1ps
`default_nettype none
module prws_cpu_model (
   input  wire logic        core_clk,           // clock
   input  wire logic [8:0]  selVec,             // packed selects
   input  wire logic [7:0]  rdData,             // read data
   output var  logic [23:0] busAddr = 24'h0,    // address
   output var  logic        busRd = 1'b0,       // read
   output var  logic        busWr = 1'b0,       // write
   output var  logic [7:0]  busWrData = 8'h0    // data
);
   task automatic acc(input logic [23:0] a, input logic w, input logic [7:0] d,
                      output logic [8:0] s, output logic [7:0] q);
      @(negedge core_clk);
      busAddr = a;
      busWrData = d;
      busRd = !w;
      busWr = w;
      #10 s = selVec;
      @(negedge core_clk);
      busRd = 1'b0;
      busWr = 1'b0;
      busAddr = ~a;
      busWrData = ~d;
      q = rdData;
   endtask
endmodule // prws_cpu_model
`default_nettype wire

/* sim/prws_monitor.sv */
// Purpose: port assertions for the window select block
// Assumes: one clock, async active-low reset
// Notes:   decode ranges come from the shared header
`timescale 1ns/1ps
`default_nettype none
`include "prws_regs.vh"
module prws_monitor (
   input wire logic        core_clk,          // clock
   input wire logic        rst_n,             // reset
   input wire logic [23:0] busAddr,           // address
   input wire logic        busRd,             // read
   input wire logic        busWr,             // write
   input wire logic [7:0]  busWrData,         // data
   input wire logic        busRdValid_r,      // valid
   input wire logic        timerSel,          // sel
   input wire logic        keypadSel,         // sel
   input wire logic        asyncSerialCh1Sel, // sel
   input wire logic        asyncSerialCh2Sel, // sel
   input wire logic        twowireCh1Sel,     // sel
   input wire logic        pwmConverterSel,   // sel
   input wire logic        twowireCh0Sel,     // sel
   input wire logic        twowireResetSel,   // sel
   input wire logic        prohibitedAccess,  // flag
   input wire logic        onchipRamEnable,   // level
   input wire logic        extendedMapSelect  // level
);
   function automatic logic inr(input logic [23:0] x, a, b, c, d);
      return (x >= a && x <= b) || (x >= c && x <= d);
   endfunction
   wire logic stb = busRd | busWr;
   wire logic kt = stb && inr(busAddr, `PRWS_KT_A_LO, `PRWS_KT_A_HI, `PRWS_KT_B_LO, `PRWS_KT_B_HI);
   wire logic s1 = stb && inr(busAddr, `PRWS_S1_A_LO, `PRWS_S1_A_HI, `PRWS_S1_B_LO, `PRWS_S1_B_HI);
   wire logic s2 = stb && inr(busAddr, `PRWS_S2_A_LO, `PRWS_S2_A_HI, `PRWS_S2_B_LO, `PRWS_S2_B_HI);
   wire logic w0 = stb && inr(busAddr, `PRWS_W0_A_LO, `PRWS_W0_A_HI, `PRWS_W0_B_LO, `PRWS_W0_B_HI);
   wire logic ownRd = busRd && busAddr >= `PRWS_ADDR_SYSCTL && busAddr <= `PRWS_ADDR_SYSCTL3;
   wire logic ramWr = busWr && busAddr == `PRWS_ADDR_SYSCTL;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   AST_EXT_IGNORE:
   assert property (extendedMapSelect |-> !(keypadSel | twowireCh1Sel | pwmConverterSel
      | twowireCh0Sel | twowireResetSel)) else $error("window bit used in extended map");
   AST_KT_DECODE:
   assert property ((timerSel | keypadSel) == kt && !(timerSel && keypadSel)) else $error("kt");
   AST_S1_DECODE:
   assert property ((asyncSerialCh1Sel | twowireCh1Sel) == s1 && !(asyncSerialCh1Sel && twowireCh1Sel))
      else $error("ch1 window decode");
   AST_S2_DECODE:
   assert property ((asyncSerialCh2Sel | pwmConverterSel) == s2 && !(asyncSerialCh2Sel && pwmConverterSel))
      else $error("ch2 window decode");
   AST_W0_DECODE:
   assert property ((twowireCh0Sel | prohibitedAccess) == w0 && !(twowireCh0Sel && prohibitedAccess))
      else $error("ch0 window decode");
   AST_RAM_WR:
   assert property (ramWr |=> onchipRamEnable == $past(busWrData[`PRWS_SC_RAMEN]))
      else $error("ram enable write");
   AST_RAM_HOLD:
   assert property (!ramWr |=> $stable(onchipRamEnable)) else $error("ram enable moved");
   AST_RD_VALID:
   assert property (busRdValid_r == $past(ownRd)) else $error("read valid timing");
   cover property (keypadSel);
   cover property (twowireCh0Sel);
   cover property (prohibitedAccess);
endmodule // prws_monitor
bind prws_window_select prws_monitor mon (.core_clk, .rst_n, .busAddr, .busRd, .busWr,
   .busWrData, .busRdValid_r, .timerSel, .keypadSel, .asyncSerialCh1Sel, .asyncSerialCh2Sel,
   .twowireCh1Sel, .pwmConverterSel, .twowireCh0Sel, .twowireResetSel, .prohibitedAccess,
   .onchipRamEnable, .extendedMapSelect);
`default_nettype wire

/* sim/tb_peripheral_register_window_select.sv */
// Purpose: directed scenarios for the window select block
// Assumes: cpu model issues one access per call
// Notes:   selects packed timer..reset, msb first
`timescale 1ns/1ps
`default_nettype none
`include "prws_regs.vh"
module tb_peripheral_register_window_select;
   logic core_clk = 1'b0, rst_n = 1'b0;
   int errors = 0, checks_done = 0, cycles = 0;
   logic [8:0] s;
   logic [7:0] q;
   logic [23:0] wa[4] = '{24'hFFFF89, 24'hFFFFA6, 24'hFFFFDE, 24'hFFFEE6};
   logic [8:0] we[2][4] = '{'{9'h040, 9'h020, 9'h002, 9'h000}, '{9'h010, 9'h008, 9'h004, 9'h001}};
   wire logic [23:0] busAddr;
   wire logic [7:0] busWrData, busRdData_r;
   wire logic [2:0] twowireRateSel;
   wire logic busRd, busWr, busRdValid_r, timerSel, keypadSel, asyncSerialCh1Sel, asyncSerialCh2Sel,
      twowireCh1Sel, pwmConverterSel, twowireCh0Sel, twowireResetSel, prohibitedAccess,
      onchipRamEnable, extendedMapSelect;
   prws_window_select dut (.core_clk, .rst_n, .busAddr, .busRd, .busWr, .busWrData, .busRdData_r,
      .busRdValid_r, .timerSel, .keypadSel, .asyncSerialCh1Sel, .asyncSerialCh2Sel, .twowireCh1Sel,
      .pwmConverterSel, .twowireCh0Sel, .twowireResetSel, .prohibitedAccess, .onchipRamEnable,
      .twowireRateSel, .extendedMapSelect);
   prws_cpu_model cpu (.core_clk, .selVec({timerSel, keypadSel, asyncSerialCh1Sel,
      asyncSerialCh2Sel, twowireCh1Sel, pwmConverterSel, twowireCh0Sel, prohibitedAccess,
      twowireResetSel}), .rdData(busRdData_r), .busAddr, .busRd, .busWr, .busWrData);
   always #50 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 1000) begin
         errors++;
         test_done;
      end
   end
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic test_done;
      $display("errors %0d checks %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic t_reset;
      chk(onchipRamEnable, 9'h001);
      chk(twowireRateSel, 9'h000);
      chk(extendedMapSelect, 9'h000);
      cpu.acc(`PRWS_ADDR_SYSCTL, 1'b0, 8'h00, s, q);
      chk(q, 9'h001);
   endtask
   task automatic t_keypad;
      cpu.acc(24'hFFFFF0, 1'b0, 8'h00, s, q);
      chk(s, 9'h100);
      cpu.acc(`PRWS_ADDR_SYSCTL, 1'b1, 8'h03, s, q);
      cpu.acc(24'hFFFFFF, 1'b0, 8'h00, s, q);
      chk(s, 9'h080);
      cpu.acc(24'hFFFFF8, 1'b1, 8'h55, s, q);
      chk(s, 9'h000);
   endtask
   task automatic t_serial;
      for (int w = 0; w < 2; w++) begin
         cpu.acc(`PRWS_ADDR_STCTL, 1'b1, w ? 8'hF0 : 8'hA0, s, q);
         chk(twowireRateSel, w ? 9'h007 : 9'h005);
         for (int i = 0; i < 4; i++) begin
            cpu.acc(wa[i], i[0], 8'h00, s, q);
            chk(s, we[w][i]);
         end
      end
   endtask
   task automatic t_extmap;
      cpu.acc(`PRWS_ADDR_SYSCTL3, 1'b1, 8'h20, s, q);
      chk(extendedMapSelect, 9'h001);
      cpu.acc(24'hFFFFFF, 1'b1, 8'h00, s, q);
      chk(s, 9'h100);
      cpu.acc(24'hFFFF88, 1'b0, 8'h00, s, q);
      chk(s, 9'h040);
      cpu.acc(`PRWS_ADDR_STCTL, 1'b0, 8'h00, s, q);
      chk(q, 9'h0F0);
      cpu.acc(`PRWS_ADDR_SYSCTL3, 1'b1, 8'h00, s, q);
   endtask
   task automatic t_ram;
      cpu.acc(`PRWS_ADDR_SYSCTL, 1'b1, 8'h00, s, q);
      chk(onchipRamEnable, 9'h000);
      cpu.acc(`PRWS_ADDR_SYSCTL, 1'b1, 8'hFF, s, q);
      cpu.acc(`PRWS_ADDR_SYSCTL, 1'b0, 8'h00, s, q);
      chk(q, 9'h003);
   endtask
   initial begin
      repeat (2) @(negedge core_clk);
      rst_n = 1'b1;
      t_reset;
      t_keypad;
      t_serial;
      t_extmap;
      t_ram;
      test_done;
   end
endmodule // tb_peripheral_register_window_select
`default_nettype wire
